// ---- dv/sdram_mode_assertions.sv ----
// Link assertions for the mode configuration and burst sequencer pair.
// Assumes the bench wires these inputs to the shared link interface.
`timescale 1ns/1ps
module sdram_mode_checker
  import sdram_mode_pkg::*;
(
  input wire logic             ref_clk_i, // Clock
  input wire logic             rst_n_i,   // Async reset, low
  input wire logic             cs_n,      // Command select
  input wire logic [2:0]       cmd,       // Command code
  input wire logic [CFG_W-1:0] addr,      // Address
  input wire logic             ctl_dq_oe, // Controller drives dq
  input wire logic             dev_dq_oe  // Device drives dq
);
  logic [CFG_W-1:0] mode_r;
  logic             lmr;
  logic             wr;
  logic             idle;
  logic             nrm;
  logic             rd;
  logic             lat2;
  logic [2:0]       bl;

  assign lmr  = !cs_n && cmd == CMD_LMR;
  assign wr   = !cs_n && cmd == CMD_WRITE;
  assign idle = cs_n || cmd == CMD_NOP;
  assign nrm  = mode_r[OPM_HI:OPM_LO] == OPM_NORMAL;
  assign rd   = !cs_n && cmd == CMD_READ && nrm;
  assign lat2 = mode_r[RL_MSB:RL_LSB] == RL_2;
  assign bl   = mode_r[BL_MSB:BL_LSB];

  // Shadow copy, since the stored value is not on the link
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_r <= MODE_RESET;
    else if (lmr)
      mode_r <= addr;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  rd_lat2_a: assert property (rd && lat2 ##1 !wr |-> ##1 dev_dq_oe)
    else $error("read data late at latency two");
  rd_lat3_a: assert property (rd && !lat2 ##1 !wr[*2] |-> ##1 dev_dq_oe)
    else $error("read data late at latency three");
  oe_cause_a: assert property ($rose(dev_dq_oe) |-> $past(rd, 2) || $past(rd, 3))
    else $error("device drives dq at wrong time");
  rd_end_a: assert property
    (rd && lat2 && bl == BL_1 ##1 idle[*2] |-> dev_dq_oe ##1 !dev_dq_oe)
    else $error("single read burst wrong length");
  wr_burst_a: assert property
    (wr && nrm && !mode_r[WB_BIT] && bl == BL_4 |-> ctl_dq_oe[*4])
    else $error("write burst of four cut short");
  wr_single_a: assert property
    (wr && nrm && mode_r[WB_BIT] |=> !ctl_dq_oe || wr)
    else $error("single write drove extra beats");
  ctl_oe_a: assert property ($rose(ctl_dq_oe) |-> wr)
    else $error("controller drives dq without write");
  lmr_gap_a: assert property (lmr |=> idle)
    else $error("command right after load");

  cover property (rd && lat2);
  cover property (rd && !lat2);
  cover property (lmr);
endmodule

// ---- dv/tb.sv ----
// Self-checking bench: controller and device ends joined over the link.
// Assumes a behavioural array that returns a word derived from the column.
`timescale 1ns/1ps
module tb;
  import sdram_mode_pkg::*;

  logic             ref_clk_i;
  logic             rst_n_i;
  logic             usr_valid_i;
  logic [1:0]       usr_op_i;
  logic [CFG_W-1:0] usr_addr_i;
  logic [DQ_W-1:0]  usr_wdata_i;
  logic             usr_ready_o;
  logic             wdata_req_o;
  logic [DQ_W-1:0]  rdata_o;
  logic             rdata_valid_o;
  logic [COL_W-1:0] mem_col_o;
  logic             mem_rd_o;
  logic             mem_wr_o;
  logic [DQ_W-1:0]  mem_wdata_o;
  logic [DQ_W-1:0]  mem_rdata_i;
  logic [CFG_W-1:0] mode_cfg_o;
  logic [DQ_W-1:0]  wbase;
  logic [DQ_W-1:0]  wofs;
  logic [24:0]      rq[$];
  logic [24:0]      wq[$];
  int               num_errors;
  int               tests_run;
  int               seed;

  sdram_mode_if i_sdram_mode_if ();
  sdram_mode_ctrl i_sdram_mode_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .link(i_sdram_mode_if), .usr_valid_i(usr_valid_i), .usr_op_i(usr_op_i),
    .usr_addr_i(usr_addr_i), .usr_wdata_i(usr_wdata_i), .usr_ready_o(usr_ready_o),
    .wdata_req_o(wdata_req_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o));
  sdram_mode_device i_sdram_mode_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .link(i_sdram_mode_if), .mem_col_o(mem_col_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .mode_cfg_o(mode_cfg_o));
  sdram_mode_checker u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cs_n(i_sdram_mode_if.cs_n), .cmd(i_sdram_mode_if.cmd), .addr(i_sdram_mode_if.addr),
    .ctl_dq_oe(i_sdram_mode_if.ctl_dq_oe), .dev_dq_oe(i_sdram_mode_if.dev_dq_oe));

  assign mem_rdata_i = {7'h2A, mem_col_o};
  // Write data is the scenario base plus the beats already taken
  assign usr_wdata_i = wbase + wofs;

  always #10 ref_clk_i = ~ref_clk_i;

  // Collect beats; advance write data on every beat taken
  always @(posedge ref_clk_i)
  begin
    if (rdata_valid_o === 1'b1)
      rq.push_back({9'h000, rdata_o});
    if (mem_wr_o === 1'b1)
      wq.push_back({mem_col_o, mem_wdata_o});
    if (!rst_n_i)
      wofs <= #1 16'h0000;
    else if (usr_valid_i && usr_ready_o)
      wofs <= #1 (usr_op_i == OP_WRITE) ? 16'h0001 : 16'h0000;
    else if (wdata_req_o)
      wofs <= #1 wofs + 16'h0001;
  end

  function automatic logic [8:0] ecol(input logic [8:0] s, input int k,
                                      input logic [2:0] code, input logic il);
    logic [8:0] m;
    m = (code == BL_FULL) ? 9'h1FF : 9'((1 << code) - 1);
    if (il && code != BL_FULL)
      return (s & ~m) | ((s ^ 9'(k)) & m);
    return (s & ~m) | ((s + 9'(k)) & m);
  endfunction

  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      num_errors++;
      $display("unexpected at %0t: count %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [1:0] o, input logic [CFG_W-1:0] a);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    #1;
    usr_valid_i = 1'b1;
    usr_op_i = o;
    usr_addr_i = a;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (usr_ready_o !== 1'b1 && n < 50);
    chk_n(n < 50, 1);
    #1;
    usr_valid_i = 1'b0;
  endtask

  task automatic run(input logic [2:0] code, input logic il, input logic lat3,
                     input logic wb, input logic [1:0] opm);
    logic [CFG_W-1:0] cfg;
    logic [8:0]       s;
    int               nb;
    cfg = {2'h0, wb, opm, lat3 ? 3'h3 : 3'h2, il, code};
    op(OP_LOAD, cfg);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({13'h0, mode_cfg_o}, {13'h0, cfg});
    s = 9'($random(seed));
    wbase = 16'($random(seed));
    if (code == BL_FULL)
      s = 9'h1FC;
    for (int w = 0; w < 2; w++)
    begin
      rq.delete();
      wq.delete();
      op(w ? OP_WRITE : OP_READ, {3'h0, s});
      if (code == BL_FULL)
      begin
        repeat (4) @(posedge ref_clk_i);
        op(OP_STOP, '0);
      end
      repeat (16) @(posedge ref_clk_i);
      nb = (w && wb) ? 1 : ((code == BL_FULL) ? 6 : (1 << code));
      if (opm != OPM_NORMAL)
        nb = 0;
      chk_n(w ? wq.size() : rq.size(), nb);
      for (int k = 0; k < nb; k++)
        if (w)
          chk(wq[k], {ecol(s, k, code, il), wbase + 16'(k)});
        else
          chk(rq[k], {9'h000, 7'h2A, ecol(s, k, code, il)});
    end
    chk({13'h0, mode_cfg_o}, {13'h0, cfg});
  endtask

  initial
  begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    usr_valid_i = 1'b0;
    usr_op_i = OP_LOAD;
    usr_addr_i = '0;
    wbase = '0;
    num_errors = 0;
    tests_run = 0;
    seed = 32'h00EB;
    repeat (20) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    for (int c = 0; c < 5; c++)
      for (int i = 0; i < 4; i++)
        run((c == 4) ? BL_FULL : 3'(c), i[0], i[1], i[0] ^ i[1], OPM_NORMAL);
    run(BL_4, 1'b0, 1'b0, 1'b0, 2'h1);
    end_sim();
  end

  // Whole run needs about 900 cycles
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule

// ---- verilog/sdram_mode_ctrl.sv ----
// Controller end: issues load, read, write and terminate commands.
// Assumes the user only loads with all banks idle and avoids reserved codes.
`timescale 1ns/1ps
module sdram_mode_ctrl
  import sdram_mode_pkg::*;
(
  input  wire logic             ref_clk_i,     // Clock
  input  wire logic             rst_n_i,       // Async reset, low
  sdram_mode_if.ctl             link,          // Command link
  input  wire logic             usr_valid_i,   // Request valid
  input  wire logic [1:0]       usr_op_i,      // Request operation
  input  wire logic [CFG_W-1:0] usr_addr_i,    // Config or column
  input  wire logic [DQ_W-1:0]  usr_wdata_i,   // Write data
  output logic                  usr_ready_o,   // Request taken
  output logic                  wdata_req_o,   // Next write beat taken
  output logic [DQ_W-1:0]       rdata_o,       // Read data
  output logic                  rdata_valid_o  // Read data strobe
);

  logic [CFG_W-1:0]  mode_r;
  logic [1:0]        mrd_cnt_r;
  logic [COL_W-1:0]  wr_left_r;
  logic              wr_fp_r;
  logic              cs_n_r;
  logic [2:0]        cmd_r;
  logic [CFG_W-1:0]  addr_r;
  logic [DQ_W-1:0]   dq_r;
  logic              dq_oe_r;
  logic              accept;
  logic [2:0]        op_cmd;

  // Hold off after load so the device sees a quiet gap
  assign usr_ready_o = mrd_cnt_r == 2'h0 && wr_left_r == '0;
  assign accept      = usr_valid_i && usr_ready_o;
  // A full-page write streams until another request truncates it
  assign wdata_req_o = wr_left_r != '0 || (wr_fp_r && !accept);

  always_comb
  begin
    case (usr_op_i)
      OP_LOAD:  op_cmd = CMD_LMR;
      OP_READ:  op_cmd = CMD_READ;
      OP_WRITE: op_cmd = CMD_WRITE;
      default:  op_cmd = CMD_BST;
    endcase
  end

  // Command issue and load spacing
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cs_n_r    <= 1'b1;
      cmd_r     <= CMD_NOP;
      addr_r    <= '0;
      mode_r    <= MODE_RESET;
      mrd_cnt_r <= 2'h0;
    end
    else
    begin
      cs_n_r <= !accept;
      cmd_r  <= accept ? op_cmd : CMD_NOP;
      if (accept)
        addr_r <= usr_addr_i;
      if (accept && usr_op_i == OP_LOAD)
      begin
        mode_r    <= usr_addr_i;
        mrd_cnt_r <= TMRD_CYCLES - 2'h1;
      end
      else if (mrd_cnt_r != 2'h0)
        mrd_cnt_r <= mrd_cnt_r - 2'h1;
    end
  end

  // Write beats; bursts follow the copy of the configuration
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_left_r <= '0;
      wr_fp_r   <= 1'b0;
      dq_r      <= '0;
      dq_oe_r   <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        wr_fp_r   <= 1'b0;
        wr_left_r <= '0;
        if (usr_op_i == OP_WRITE && !mode_r[WB_BIT])
        begin
          wr_fp_r   <= mode_r[BL_MSB:BL_LSB] == BL_FULL;
          wr_left_r <= last_of(mode_r[BL_MSB:BL_LSB]);
        end
      end
      else if (wr_left_r != '0)
        wr_left_r <= wr_left_r - 9'h001;
      dq_oe_r <= (accept && usr_op_i == OP_WRITE) || wdata_req_o;
      dq_r    <= usr_wdata_i;
    end
  end

  // Read capture follows the device drive window
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      rdata_o       <= link.dq;
      rdata_valid_o <= link.dev_dq_oe;
    end
  end

  assign link.cs_n       = cs_n_r;
  assign link.cmd        = cmd_r;
  assign link.addr       = addr_r;
  assign link.ctl_dq_out = dq_r;
  assign link.ctl_dq_oe  = dq_oe_r;

endmodule

// ---- verilog/sdram_mode_device.sv ----
// Device end: mode configuration, burst column sequencer, read latency.
// Assumes the controller keeps load timing and avoids reserved codes.
`timescale 1ns/1ps
module sdram_mode_device
  import sdram_mode_pkg::*;
(
  input  wire logic             ref_clk_i,   // Clock
  input  wire logic             rst_n_i,     // Async reset, low
  sdram_mode_if.dev             link,        // Command link
  output logic [COL_W-1:0]      mem_col_o,   // Array column
  output logic                  mem_rd_o,    // Array read beat
  output logic                  mem_wr_o,    // Array write beat
  output logic [DQ_W-1:0]       mem_wdata_o, // Array write data
  input  wire logic [DQ_W-1:0]  mem_rdata_i, // Array read data
  output logic [CFG_W-1:0]      mode_cfg_o   // Stored configuration
);

  logic [CFG_W-1:0]  mode_r;
  burst_state_t      state_r;
  logic [COL_W-1:0]  start_r;
  logic [COL_W-1:0]  idx_r;
  logic [COL_W-1:0]  last_r;
  logic              full_r;
  logic              pipe_v_r;
  logic [DQ_W-1:0]   pipe_d_r;
  logic              dq_oe_r;
  logic [DQ_W-1:0]   dq_out_r;

  logic              is_lmr;
  logic              is_rd;
  logic              is_wr;
  logic              is_bst;
  logic              normal;
  logic              new_rd;
  logic              new_wr;
  logic [2:0]        bl_code;
  logic              interleave;
  logic              single_wr;
  logic              lat2;
  logic              beat_now;
  logic              beat_rd;
  logic [COL_W-1:0]  beat_col;
  logic [COL_W-1:0]  new_last;
  logic              new_full;

  always_comb
  begin
    is_lmr = !link.cs_n && link.cmd == CMD_LMR;
    is_rd  = !link.cs_n && link.cmd == CMD_READ;
    is_wr  = !link.cs_n && link.cmd == CMD_WRITE;
    is_bst = !link.cs_n && link.cmd == CMD_BST;
  end

  // Reserved operating modes suppress accesses
  assign normal     = mode_r[OPM_HI:OPM_LO] == OPM_NORMAL;
  assign new_rd     = is_rd && normal;
  assign new_wr     = is_wr && normal;
  assign bl_code    = mode_r[BL_MSB:BL_LSB];
  assign interleave = mode_r[BT_BIT];
  assign single_wr  = mode_r[WB_BIT];
  assign lat2       = mode_r[RL_MSB:RL_LSB] == RL_2;

  // Burst shape of a newly registered command
  always_comb
  begin
    new_full = bl_code == BL_FULL;
    new_last = last_of(bl_code);
    if (new_wr && single_wr)
    begin
      new_full = 1'b0;
      new_last = '0;
    end
  end

  // Current access: the command cycle itself, then the burst continuation
  always_comb
  begin
    if (new_rd || new_wr)
    begin
      beat_now = 1'b1;
      beat_rd  = new_rd;
      beat_col = col_of(link.addr[COL_W-1:0], '0, bl_code, interleave);
    end
    else
    begin
      beat_now = state_r != S_IDLE && !is_bst;
      beat_rd  = state_r == S_READ;
      beat_col = col_of(start_r, idx_r, bl_code, interleave);
    end
  end

  // Configuration register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_r <= MODE_RESET;
    else if (is_lmr)
      mode_r <= link.addr;
  end

  // Burst shape latched with each accepted command
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      start_r <= '0;
      last_r  <= '0;
      full_r  <= 1'b0;
    end
    else if (new_rd || new_wr)
    begin
      start_r <= link.addr[COL_W-1:0];
      last_r  <= new_last;
      full_r  <= new_full;
    end
  end

  // Burst sequencing; a new command truncates the running burst
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= S_IDLE;
      idx_r   <= '0;
    end
    else if (new_rd || new_wr)
    begin
      idx_r   <= 9'h001;
      if (!new_full && new_last == '0)
        state_r <= S_IDLE;
      else if (new_rd)
        state_r <= S_READ;
      else
        state_r <= S_WRITE;
    end
    else if (is_bst)
      state_r <= S_IDLE;
    else
    begin
      case (state_r)
        S_READ, S_WRITE:
        begin
          // Nine-bit index wraps at page end by itself
          idx_r <= idx_r + 9'h001;
          if (!full_r && idx_r == last_r)
            state_r <= S_IDLE;
        end
        S_IDLE:
          state_r <= S_IDLE;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // Array access strobes
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_col_o   <= '0;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= '0;
    end
    else
    begin
      mem_col_o   <= beat_col;
      mem_rd_o    <= beat_now && beat_rd;
      mem_wr_o    <= beat_now && !beat_rd;
      mem_wdata_o <= link.dq;
    end
  end

  // Read latency pipeline; a write command kills pending read data
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pipe_v_r <= 1'b0;
      pipe_d_r <= '0;
    end
    else
    begin
      pipe_v_r <= mem_rd_o && !is_wr;
      pipe_d_r <= mem_rdata_i;
    end
  end

  // Output drive; two-clock latency skips the extra stage
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dq_oe_r  <= 1'b0;
      dq_out_r <= '0;
    end
    else
    begin
      if (is_wr)
        dq_oe_r <= 1'b0;
      else if (lat2)
        dq_oe_r <= mem_rd_o;
      else
        dq_oe_r <= pipe_v_r;
      if (lat2)
        dq_out_r <= mem_rdata_i;
      else
        dq_out_r <= pipe_d_r;
    end
  end

  assign link.dev_dq_out = dq_out_r;
  assign link.dev_dq_oe  = dq_oe_r;
  assign mode_cfg_o      = mode_r;

endmodule

// ---- verilog/sdram_mode_if.sv ----
// Command, address and data link between controller and device ends.
// Assumes both ends run on the same clock; dq level resolved here.
`timescale 1ns/1ps
interface sdram_mode_if;
  import sdram_mode_pkg::*;

  logic              cs_n;
  logic [2:0]        cmd;
  logic [CFG_W-1:0]  addr;
  logic [DQ_W-1:0]   ctl_dq_out;
  logic              ctl_dq_oe;
  logic [DQ_W-1:0]   dev_dq_out;
  logic              dev_dq_oe;
  logic [DQ_W-1:0]   dq;

  // Undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

  modport dev (
    input  cs_n,
    input  cmd,
    input  addr,
    input  dq,
    output dev_dq_out,
    output dev_dq_oe
  );

  modport ctl (
    output cs_n,
    output cmd,
    output addr,
    output ctl_dq_out,
    output ctl_dq_oe,
    input  dq,
    input  dev_dq_oe
  );
endinterface

// ---- verilog/sdram_mode_pkg.sv ----
// Shared constants for the mode configuration and burst sequencer pair.
// Assumes one 50 MHz clock shared by the device end and the controller end.
// Functional notes
// - Configuration changes only on load-mode command
// - Field layout: length, type, latency, mode, write
// - Controller loads configuration only with banks idle
// - Controller waits after load before next operation
// - At least two cycles after load command
// - Lengths 1,2,4,8; full page sequential only
// - Length bounds columns; full page until terminate
// - Controller avoids reserved field encodings
// - Fixed bursts wrap inside aligned column block
// - Block chosen by upper column bits, offset low
// - Full page increments, wraps at page end
// - Burst type bit selects column ordering
// - Sequential adds offset; interleaved XORs index
// - Read latency two or three clocks
// - Drive from edge n+m-1, valid by n+m
// - Operating mode zero is normal operation
// - Write burst bit set gives single writes
package sdram_mode_pkg;

  localparam int CFG_W = 12;
  localparam int COL_W = 9;
  localparam int DQ_W  = 16;

  // Configuration field positions
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int BT_BIT = 3;
  localparam int RL_LSB = 4;
  localparam int RL_MSB = 6;
  localparam int OPM_LO = 7;
  localparam int OPM_HI = 8;
  localparam int WB_BIT = 9;

  localparam logic [CFG_W-1:0] MODE_RESET = 12'h000;

  // Burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  localparam logic [2:0] RL_2       = 3'h2;
  localparam logic [1:0] OPM_NORMAL = 2'h0;

  // Column masks per length
  localparam logic [COL_W-1:0] MASK_1    = 9'h000;
  localparam logic [COL_W-1:0] MASK_2    = 9'h001;
  localparam logic [COL_W-1:0] MASK_4    = 9'h003;
  localparam logic [COL_W-1:0] MASK_8    = 9'h007;
  localparam logic [COL_W-1:0] MASK_PAGE = 9'h1FF;

  // Link commands, coded as {ras, cas, we}
  localparam logic [2:0] CMD_LMR   = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_BST   = 3'h6;
  localparam logic [2:0] CMD_NOP   = 3'h7;

  // Controller user operations
  localparam logic [1:0] OP_LOAD  = 2'h0;
  localparam logic [1:0] OP_READ  = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_STOP  = 2'h3;

  localparam logic [1:0] TMRD_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_READ  = 3'b010,
    S_WRITE = 3'b100
  } burst_state_t;

  // Column of access idx in a burst starting at start
  function automatic logic [COL_W-1:0] col_of(
    input logic [COL_W-1:0] start,
    input logic [COL_W-1:0] idx,
    input logic [2:0]       code,
    input logic             interleave
  );
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] off;
    case (code)
      BL_2:    mask = MASK_2;
      BL_4:    mask = MASK_4;
      BL_8:    mask = MASK_8;
      BL_FULL: mask = MASK_PAGE;
      default: mask = MASK_1;
    endcase
    // Full page has no interleaved form
    if (interleave && code != BL_FULL)
      off = start ^ idx;
    else
      off = start + idx;
    return (start & ~mask) | (off & mask);
  endfunction

  // Index of the last access of a fixed burst
  function automatic logic [COL_W-1:0] last_of(input logic [2:0] code);
    case (code)
      BL_2:    return MASK_2;
      BL_4:    return MASK_4;
      BL_8:    return MASK_8;
      default: return MASK_1;
    endcase
  endfunction

endpackage
